//--- pkg/lpm_map.svh
// Timing counts and counter width for the low-power mode controller.
// Assumes a 125 MHz core clock; included by bare name.
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define LPM_CLK_MHZ         125
`define LPM_ENTRY_MIN_NS    800
`define LPM_EXIT_MIN_US     200
// Least times round up to whole cycles
`define LPM_ENTRY_CYCLES    ((`LPM_ENTRY_MIN_NS * `LPM_CLK_MHZ + 999) / 1000)
`define LPM_EXIT_CYCLES     (`LPM_EXIT_MIN_US * `LPM_CLK_MHZ)
`define LPM_INIT_CYCLES     16
`define LPM_CNT_W           16
`endif

//--- pkg/lpm_pkg.sv
// Types for the low-power mode controller.
// Assumes lpm_map.svh supplies the widths.
`include "lpm_map.svh"
package lpm_pkg;
  typedef enum logic [3:0] {
    ST_RUN   = 4'h1,
    ST_SLEEP = 4'h2,
    ST_WAKE  = 4'h4,
    ST_INIT  = 4'h8
  } lpm_state_t;

  typedef struct packed {
    logic core_on;
    logic in_buf_en;
    logic out_buf_en;
    logic regs_clear;
    logic init_busy;
  } lpm_ctrl_t;
endpackage

//--- hw/lpm_level_timer.sv
// Counts cycles a level has stood and flags when a length is passed.
// Assumes a synchronised, glitch-free level on the core clock.
`timescale 1ns/1ns
`include "lpm_map.svh"
module lpm_level_timer #(
  parameter logic [`LPM_CNT_W-1:0] LIMIT = 16'h0001
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic en_in,
  input  wire logic level_in,
  output logic      done_out
);
  logic [`LPM_CNT_W-1:0] cnt_q;

  // Any drop of the level restarts the count
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt_q <= 16'h0000;
    end else if (en_in) begin
      if (!level_in) begin
        cnt_q <= 16'h0000;
      end else if (cnt_q != LIMIT) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  assign done_out = (cnt_q == LIMIT);
endmodule

//--- hw/low_power_mode_control.sv
// Low-power mode sequencer: qualifies the request pin, powers the core
// down, isolates I/O, and re-initialises on exit.
// Assumes the request pin is asynchronous to clk_in.
//
// Behaviour
// - Enter low power only after request held high longer than 800 ns.
// - In low power the core logic is switched off.
// - In low power input buffers off, outputs and bidirectionals tristated.
// - Register contents are lost; full re-initialisation on leaving.
// - After the exit time is met, initialisation runs before resuming.
`timescale 1ns/1ns
`include "lpm_map.svh"
module low_power_mode_control
  import lpm_pkg::*;
(
  // Clock, reset, enable
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic ce_in,
  // Request pin from the system controller
  input  wire logic low_power_request_in,
  // Power and isolation controls
  output logic      core_on_out,
  output logic      in_buf_en_out,
  output logic      out_buf_en_out,
  output logic      regs_clear_out,
  output logic      init_busy_out,
  output logic      low_power_out
);
  localparam logic [`LPM_CNT_W-1:0] ENTRY_LIM = `LPM_CNT_W'(`LPM_ENTRY_CYCLES + 1);
  localparam logic [`LPM_CNT_W-1:0] EXIT_LIM  = `LPM_CNT_W'(`LPM_EXIT_CYCLES + 1);
  // Count runs 0 to limit, so one less gives the full init length
  localparam logic [`LPM_CNT_W-1:0] INIT_LIM  = `LPM_CNT_W'(`LPM_INIT_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic sync1_q;
  logic req_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync1_q <= 1'b0;
      req_q   <= 1'b0;
    end else if (ce_in) begin
      sync1_q <= low_power_request_in;
      req_q   <= sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Level timers
  lpm_state_t state_q;
  lpm_state_t state_d;
  logic       entry_done;
  logic       exit_done;
  logic [`LPM_CNT_W-1:0] init_cnt_q;

  // Strictly longer than the minimum, hence the extra cycle
  lpm_level_timer #(.LIMIT(ENTRY_LIM)) u_entry (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .en_in    (ce_in),
    .level_in (req_q && state_q == ST_RUN),
    .done_out (entry_done)
  );

  // Charge pumps need the low level to stand long enough
  lpm_level_timer #(.LIMIT(EXIT_LIM)) u_exit (
    .clk_in   (clk_in),
    .nrst_in  (nrst_in),
    .en_in    (ce_in),
    .level_in (!req_q && (state_q == ST_SLEEP || state_q == ST_WAKE)),
    .done_out (exit_done)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (entry_done) begin
          state_d = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (!req_q) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (req_q) begin
          state_d = ST_SLEEP;
        end else if (exit_done) begin
          state_d = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_cnt_q == INIT_LIM) begin
          state_d = ST_RUN;
        end
      end
      default: state_d = ST_RUN;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_q <= ST_RUN;
    end else if (ce_in) begin
      state_q <= state_d;
    end
  end

  // Initialisation length counter
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      init_cnt_q <= 16'h0000;
    end else if (ce_in) begin
      if (state_q != ST_INIT) begin
        init_cnt_q <= 16'h0000;
      end else if (init_cnt_q != INIT_LIM) begin
        init_cnt_q <= init_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, registered
  lpm_ctrl_t ctrl_q;
  logic      asleep;
  assign asleep = (state_d == ST_SLEEP) || (state_d == ST_WAKE);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ctrl_q <= '{core_on: 1'b1, in_buf_en: 1'b1, out_buf_en: 1'b1,
                  regs_clear: 1'b0, init_busy: 1'b0};
    end else if (ce_in) begin
      // Core stays off until initialisation has finished
      ctrl_q.core_on    <= !asleep && state_d != ST_INIT;
      ctrl_q.in_buf_en  <= !asleep && state_d != ST_INIT;
      ctrl_q.out_buf_en <= !asleep && state_d != ST_INIT;
      // Core state is not kept; clear held until init ends
      ctrl_q.regs_clear <= asleep || state_d == ST_INIT;
      ctrl_q.init_busy  <= state_d == ST_INIT;
    end
  end

  assign core_on_out    = ctrl_q.core_on;
  assign in_buf_en_out  = ctrl_q.in_buf_en;
  assign out_buf_en_out = ctrl_q.out_buf_en;
  assign regs_clear_out = ctrl_q.regs_clear;
  assign init_busy_out  = ctrl_q.init_busy;
  assign low_power_out  = !ctrl_q.core_on;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  // Own count of the held level, so the entry check does not trust the timer
  logic [`LPM_CNT_W-1:0] hold_cnt_q;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hold_cnt_q <= 16'h0000;
    end else if (ce_in) begin
      if (!req_q) begin
        hold_cnt_q <= 16'h0000;
      end else if (hold_cnt_q != 16'hFFFF) begin
        hold_cnt_q <= hold_cnt_q + 16'h0001;
      end
    end
  end

  property p_entry_needs_hold;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(state_q == ST_SLEEP) && $past(state_q) == ST_RUN |-> $past(hold_cnt_q) > `LPM_ENTRY_CYCLES;
  endproperty
  a_entry_needs_hold: assert property (p_entry_needs_hold) else $error("sleep before hold time");
  property p_entry_qualified;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(state_q == ST_SLEEP) && $past(state_q) == ST_RUN |-> $past(entry_done);
  endproperty
  a_entry_qualified: assert property (p_entry_qualified) else $error("sleep without hold");

  property p_core_off;
    @(posedge clk_in) disable iff (!nrst_in)
      (state_q == ST_SLEEP) && $past(state_q == ST_SLEEP) |-> !core_on_out;
  endproperty
  a_core_off: assert property (p_core_off) else $error("core on while asleep");

  property p_io_isolated;
    @(posedge clk_in) disable iff (!nrst_in)
      !core_on_out |-> !in_buf_en_out && !out_buf_en_out;
  endproperty
  a_io_isolated: assert property (p_io_isolated) else $error("io active while asleep");

  property p_regs_cleared;
    @(posedge clk_in) disable iff (!nrst_in)
      $fell(core_on_out) |-> regs_clear_out;
  endproperty
  a_regs_cleared: assert property (p_regs_cleared) else $error("regs kept in sleep");

  property p_init_after_exit;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(state_q == ST_INIT) |-> $past(exit_done) && !$past(req_q);
  endproperty
  a_init_after_exit: assert property (p_init_after_exit) else $error("init without exit time");

  property p_init_before_run;
    @(posedge clk_in) disable iff (!nrst_in)
      $rose(core_on_out) |-> $past(init_busy_out);
  endproperty
  a_init_before_run: assert property (p_init_before_run) else $error("resume without init");

  property p_early_drop;
    @(posedge clk_in) disable iff (!nrst_in)
      ce_in && state_q == ST_RUN && !req_q && !entry_done |=> state_q == ST_RUN;
  endproperty
  a_early_drop: assert property (p_early_drop) else $error("sleep after early drop");

  property p_short_high_stays;
    @(posedge clk_in) disable iff (!nrst_in)
      ce_in && state_q == ST_RUN && $rose(req_q) |=> state_q == ST_RUN [*8];
  endproperty
  a_short_high_stays: assert property (p_short_high_stays) else $error("entry too early");
endmodule

//--- dv/lpm_sys_ctrl_model.sv
// System controller model that drives the low-power request pin.
// Assumes want_in changes just after a rising edge of clk_in.
`timescale 1ns/1ns
module lpm_sys_ctrl_model (
  // Clock and command
  input  wire logic clk_in,
  input  wire logic want_in,
  // Request pin
  output logic      low_power_request_out
);
  // Pin is always driven to a defined level, never left floating
  initial low_power_request_out = 1'b0;
  // The bench decides how long each level is held
  always @(posedge clk_in) low_power_request_out <= want_in;
endmodule

//--- dv/testbench.sv
// Self-checking bench for the low-power mode controller.
// Assumes the exit count from lpm_map.svh (about 25k cycles).
`timescale 1ns/1ns
`include "lpm_map.svh"
module testbench;
  logic       clk_in;
  logic       nrst_in;
  logic       ce_in;
  logic       want;
  logic       req;
  logic       core_on, in_en, out_en, clr, busy, lp;
  wire  [5:0] lv = {core_on, in_en, out_en, clr, busy, lp};
  int         errors, samples_checked, n, k;

  lpm_sys_ctrl_model lpm_sys_ctrl_model_i (.clk_in(clk_in), .want_in(want), .low_power_request_out(req));
  low_power_mode_control low_power_mode_control_i (
    .clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in), .low_power_request_in(req),
    .core_on_out(core_on), .in_buf_en_out(in_en), .out_buf_en_out(out_en),
    .regs_clear_out(clr), .init_busy_out(busy), .low_power_out(lp));

  ////////////////////////////////////////////////////////////////////
  // One cycle for the model plus two sync flops before counting starts
  function automatic int entry_lo();
    return `LPM_ENTRY_CYCLES + 2;
  endfunction
  function automatic int exit_lo();
    return `LPM_EXIT_CYCLES + 2;
  endfunction
  function automatic logic pick(input int sel);
    return (sel == 0) ? lp : (sel == 1) ? busy : core_on;
  endfunction

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic in_range(input int v, input int lo, input int hi);
    samples_checked++;
    if (v < lo || v > hi) begin
      errors++;
      $display("mismatch at %0t got %0h exp %0h", $time, v, lo);
    end
  endtask
  task automatic step(input logic v);
    @(posedge clk_in);
    #1 want = v;
  endtask
  // Bounded wait; a hang shows as an out-of-range count
  task automatic wait_lvl(input int sel, output int cnt);
    cnt = 0;
    while (pick(sel) !== 1'b1 && cnt < 40000) begin
      @(posedge clk_in);
      #1 cnt++;
    end
  endtask
  task automatic give_verdict();
    if (errors == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end
  initial begin
    #(8 * 60000);
    errors++;
    give_verdict();
  end
  initial begin
    nrst_in = 1'b0;
    ce_in = 1'b1;
    want = 1'b0;
    errors = 0;
    samples_checked = 0;
    void'($urandom(32'h4BCF));
    repeat (5) @(posedge clk_in);
    #1 nrst_in = 1'b1;
    cmp(16'(lv), 16'h0038);
    // Frozen enable: a long high must not be counted
    @(posedge clk_in);
    #1 ce_in = 1'b0;
    want = 1'b1;
    repeat ($urandom_range(400, 150)) @(posedge clk_in);
    #1 cmp(16'(lv), 16'h0038);
    want = 1'b0;
    repeat (4) @(posedge clk_in);
    #1 ce_in = 1'b1;
    repeat (8) @(posedge clk_in);
    #1 cmp(16'(lv), 16'h0038);
    // Short highs, the first held exactly the entry time
    for (k = 0; k < 6; k++) begin
      step(1'b1);
      n = (k == 0) ? `LPM_ENTRY_CYCLES - 1 : $urandom_range(90, 1);
      repeat (n) @(posedge clk_in);
      step(1'b0);
      repeat (8) @(posedge clk_in);
      #1 cmp(16'(lv), 16'h0038);
    end
    step(1'b1);
    wait_lvl(0, n);
    in_range(n, entry_lo(), entry_lo() + 8);
    repeat (2) @(posedge clk_in);
    #1 cmp(16'(lv), 16'h0005);
    // Low too short to leave: device must stay asleep
    step(1'b0);
    repeat ($urandom_range(2000, 100)) @(posedge clk_in);
    step(1'b1);
    repeat (20) @(posedge clk_in);
    #1 cmp(16'(lv), 16'h0005);
    step(1'b0);
    wait_lvl(1, n);
    in_range(n, exit_lo(), exit_lo() + 8);
    cmp(16'(lv), 16'h0007);
    wait_lvl(2, n);
    cmp(16'(n), 16'(`LPM_INIT_CYCLES));
    cmp(16'(lv), 16'h0038);
    give_verdict();
  end
endmodule
